// ==== verilog/ihf_host_port.sv ====
// Top level of the ready, strobe, request and role logic toward the host.
// Overview of operation
// - In direct disk mode, grounded cable select means master, open means slave.
// - In card memory and I/O modes, drive wait pin low to stretch cycles.
// - In direct disk mode outside Ultra DMA, the pin is ordinary ready.
// - During an Ultra DMA write burst, assert receive-ready when words fit.
// - Negating receive-ready pauses a write; host stops until reasserted.
// - During Ultra DMA read, every strobe edge carries one data word.
// - Read bursts pause by stopping strobe edges, resume by toggling again.
// - DMA request stays high until acknowledge, and past it while data remains; outside disk mode it is held low.
// - In direct disk mode the interrupt line is active high.
module ihf_host_port
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic link_clk_i,
    input wire logic cable_select_i,
    input wire logic dma_ack_n_i,
    input wire ihf_pkg::ihf_core_req_s req_i,
    output logic ready_pin_o,
    output logic ready_pin_oe_o,
    output logic dma_req_o,
    output logic host_interrupt_line_o,
    output logic role_slave_o,
    output logic role_valid_o,
    output logic word_taken_o
);

    logic [ihf_pkg::SYNC_STAGES-1:0] csel_sync_reg;
    logic [ihf_pkg::SYNC_STAGES-1:0] ack_sync_reg;
    logic [2:0] tog_sync_reg;
    logic [ihf_pkg::SYNC_STAGES-1:0] csel_fill_reg;
    logic role_reg;
    logic role_valid_reg;
    logic pin_reg;
    logic pin_oe_reg;
    logic dma_req_reg;
    logic dma_req_next;
    logic irq_reg;
    logic taken_reg;
    logic link_strobe;
    logic link_toggle;
    ihf_pkg::ihf_pin_e pin_sel;
    ihf_pkg::ihf_link_cfg_s link_cfg_reg;

    wire is_disk = req_i.mode == ihf_pkg::IHF_MODE_DISK;
    wire in_burst = is_disk & req_i.udma_active;
    wire ack_seen = ~ack_sync_reg[1];
    wire word_edge = tog_sync_reg[2] ^ tog_sync_reg[1];

    // Pin function selection; outside a burst the pin is the wait signal.
    assign pin_sel = !in_burst ? ihf_pkg::IHF_PIN_WAIT :
        (req_i.udma_read ? ihf_pkg::IHF_PIN_STROBE : ihf_pkg::IHF_PIN_RDY);

    // In disk mode the request drops only after the host acknowledges, so no transfer is lost; leaving disk mode drops it at once.
    assign dma_req_next = dma_req_reg ? ~(ack_seen & ~req_i.dma_want) | ~ack_seen
        : req_i.dma_want;

    ihf_strobe_gen u_strobe
    (
        .link_clk_i(link_clk_i),
        .arst_n_i(arst_n_i),
        .read_burst_i(link_cfg_reg.read_burst),
        .word_valid_i(link_cfg_reg.word_valid),
        .strobe_o(link_strobe),
        .word_toggle_o(link_toggle)
    );

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            csel_sync_reg <= '0;
            ack_sync_reg <= '1;
            tog_sync_reg <= '0;
            csel_fill_reg <= '0;
            role_reg <= ihf_pkg::RESET_ROLE;
            role_valid_reg <= 1'b0;
        end
        else
        begin
            csel_sync_reg <= {csel_sync_reg[0], cable_select_i};
            ack_sync_reg <= {ack_sync_reg[0], dma_ack_n_i};
            tog_sync_reg <= {tog_sync_reg[1:0], link_toggle};
            csel_fill_reg <= {csel_fill_reg[0], 1'b1};
            // Role is caught once after release; later pin changes are ignored.
            // It waits until the synchroniser holds the pin, since its reset zero reads as master.
            if (!role_valid_reg && csel_fill_reg[1])
            begin
                role_reg <= csel_sync_reg[1] ? ihf_pkg::ROLE_SLAVE
                    : ihf_pkg::ROLE_MASTER;
                role_valid_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            link_cfg_reg <= '0;
        end
        else
        begin
            link_cfg_reg.read_burst <= pin_sel == ihf_pkg::IHF_PIN_STROBE;
            link_cfg_reg.word_valid <= req_i.tx_word_valid;
        end
    end

    // The strobe level is a link-domain flop, not the pin itself, so it is
    // re-timed here by two flops, which costs two cycles of latency.
    logic [ihf_pkg::SYNC_STAGES-1:0] strobe_sync_reg;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            strobe_sync_reg <= '0;
            pin_reg <= ihf_pkg::RESET_WAIT_PIN;
            pin_oe_reg <= 1'b0;
            dma_req_reg <= 1'b0;
            irq_reg <= 1'b0;
            taken_reg <= 1'b0;
        end
        else
        begin
            strobe_sync_reg <= {strobe_sync_reg[0], link_strobe};
            pin_oe_reg <= 1'b1;
            case (pin_sel)
                ihf_pkg::IHF_PIN_WAIT:
                    pin_reg <= ~req_i.busy;
                ihf_pkg::IHF_PIN_RDY:
                    pin_reg <= req_i.rx_ready;
                ihf_pkg::IHF_PIN_STROBE:
                    pin_reg <= strobe_sync_reg[1];
                default:
                    pin_reg <= ihf_pkg::RESET_WAIT_PIN;
            endcase
            dma_req_reg <= is_disk & dma_req_next;
            irq_reg <= is_disk & req_i.irq;
            taken_reg <= word_edge;
        end
    end

    // Cable select is sampled in every mode but only meaningful in disk mode.
    assign role_slave_o = role_reg;
    assign role_valid_o = role_valid_reg;
    assign ready_pin_o = pin_reg;
    assign ready_pin_oe_o = pin_oe_reg;
    assign dma_req_o = dma_req_reg;
    assign host_interrupt_line_o = irq_reg;
    assign word_taken_o = taken_reg;

endmodule

// ==== verilog/ihf_pkg.sv ====
// Package holding modes, structs and constants of the host flow-control port.
package ihf_pkg;

    typedef enum logic [1:0]
    {
        IHF_MODE_MEM,
        IHF_MODE_IO,
        IHF_MODE_DISK
    } ihf_mode_e;

    typedef enum logic [1:0]
    {
        IHF_PIN_WAIT,
        IHF_PIN_RDY,
        IHF_PIN_STROBE
    } ihf_pin_e;

    // Request from the core logic, on clk_i.
    typedef struct packed
    {
        ihf_mode_e mode;
        logic udma_active;
        logic udma_read;
        logic busy;
        logic rx_ready;
        logic tx_word_valid;
        logic dma_want;
        logic irq;
    } ihf_core_req_s;

    // Settings handed to the link-clock domain as levels.
    typedef struct packed
    {
        logic read_burst;
        logic word_valid;
    } ihf_link_cfg_s;

    localparam logic ROLE_MASTER = 1'b0;
    localparam logic ROLE_SLAVE = 1'b1;
    localparam logic RESET_ROLE = ROLE_SLAVE;
    localparam logic RESET_WAIT_PIN = 1'b1;
    localparam logic RESET_STROBE = 1'b0;
    localparam int SYNC_STAGES = 2;

endpackage

// ==== verilog/ihf_strobe_gen.sv ====
// Link-clock strobe generator that toggles once per transferred read word.
module ihf_strobe_gen
(
    input wire logic link_clk_i,
    input wire logic arst_n_i,
    input wire logic read_burst_i,
    input wire logic word_valid_i,
    output logic strobe_o,
    output logic word_toggle_o
);

    logic [ihf_pkg::SYNC_STAGES-1:0] burst_sync_reg;
    logic [ihf_pkg::SYNC_STAGES-1:0] valid_sync_reg;
    logic strobe_reg;
    logic toggle_reg;
    wire advance = burst_sync_reg[1] & valid_sync_reg[1];

    always_ff @(posedge link_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            burst_sync_reg <= '0;
            valid_sync_reg <= '0;
            strobe_reg <= ihf_pkg::RESET_STROBE;
            toggle_reg <= 1'b0;
        end
        else
        begin
            burst_sync_reg <= {burst_sync_reg[0], read_burst_i};
            valid_sync_reg <= {valid_sync_reg[0], word_valid_i};
            // Each edge, rising or falling, carries one word; no edge means pause.
            if (advance)
            begin
                strobe_reg <= ~strobe_reg;
                toggle_reg <= ~toggle_reg;
            end
        end
    end

    assign strobe_o = strobe_reg;
    assign word_toggle_o = toggle_reg;

endmodule

// ==== verification/ihf_host_port_asserts.sv ====
// Concurrent checks on the ports of the host flow-control port.
module ihf_host_port_asserts
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic dma_ack_n_i,
    input wire ihf_pkg::ihf_core_req_s req_i,
    input wire logic ready_pin_o,
    input wire logic dma_req_o,
    input wire logic host_interrupt_line_o,
    input wire logic role_slave_o,
    input wire logic role_valid_o,
    input wire logic word_taken_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic dk = req_i.mode == ihf_pkg::IHF_MODE_DISK;
    wire logic rd = dk && req_i.udma_active && req_i.udma_read;
    wire logic wr = dk && req_i.udma_active && !req_i.udma_read;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_irq_off: assert property (!dk |=> !host_interrupt_line_o)
        else $error("irq outside disk mode");
    chk_irq_high: assert property (dk
        |=> host_interrupt_line_o == $past(req_i.irq))
        else $error("irq not active high");
    chk_wait_busy: assert property (!req_i.udma_active
        |=> ready_pin_o != $past(req_i.busy))
        else $error("wait pin wrong");
    chk_rdy_write: assert property (wr
        |=> ready_pin_o == $past(req_i.rx_ready))
        else $error("receive ready wrong");
    chk_role_held: assert property (role_valid_o && $past(role_valid_o)
        |-> $stable(role_slave_o))
        else $error("role changed");
    // The acknowledge reaches the request logic through two flops, hence the depth of two.
    chk_dma_hold: assert property (dma_req_o && dk && $past(dma_ack_n_i, 2)
        |=> dma_req_o)
        else $error("request dropped early");
    chk_dma_rise: assert property (dk && req_i.dma_want |=> dma_req_o)
        else $error("request missing");
    chk_strobe_word: assert property (rd && $past(rd, 3) && $changed(ready_pin_o)
        |-> ##[0:6] word_taken_o)
        else $error("strobe edge without word");
    cover property (rd && word_taken_o);
    cover property (dk && $rose(dma_req_o));
    cover property ($rose(role_valid_o) && role_slave_o);
endmodule

// ==== verification/ihf_host_model.sv ====
// Host model that acknowledges DMA requests and counts strobe edges.
module ihf_host_model
(
    input wire logic clk_i,
    input wire logic dma_req_i,
    input wire logic strobe_i,
    output logic dma_ack_n_o,
    output int edges_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    logic ack_n = 1'b1;
    int count = 0;
    // The host latches a word on either edge, so both polarities count.
    always @(posedge clk_i)
    begin
        ack_n <= !dma_req_i;
        last <= strobe_i;
        if (strobe_i !== last)
            count <= count + 1;
    end
    assign dma_ack_n_o = ack_n;
    assign edges_o = count;
endmodule

// ==== verification/tb_ihf_host_port.sv ====
// Testbench of the host flow-control port with its host model.
module tb_ihf_host_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic lk = 1'b0;
    logic arst_n_i = 1'b1;
    logic cs = 1'b0;
    logic ack_n, pin, oe, dreq, irq, slv, vld, wt;
    ihf_pkg::ihf_core_req_s r = '0;
    int edges, words = 0, fail_count = 0, checks_done = 0;
    initial forever #5 clk_i = ~clk_i;
    initial #3 forever #40 lk = ~lk;
    ihf_host_port ihf_host_port_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(lk),
        .cable_select_i(cs), .dma_ack_n_i(ack_n), .req_i(r), .ready_pin_o(pin),
        .ready_pin_oe_o(oe), .dma_req_o(dreq), .host_interrupt_line_o(irq),
        .role_slave_o(slv), .role_valid_o(vld), .word_taken_o(wt));
    ihf_host_model ihf_host_model_inst (.clk_i(clk_i), .dma_req_i(dreq), .strobe_i(pin),
        .dma_ack_n_o(ack_n), .edges_o(edges));
    always @(posedge wt) words++;
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One word per link clock rise while words are offered; the two link synchroniser
    // stages delay the start and the stop alike, so the count is exact.
    localparam int LINK_RATIO = 8;
    localparam int RD_WORDS = 20;
    task automatic rst(input logic c);
        arst_n_i <= 1'b0;
        cs <= c;
        w(20);
        arst_n_i <= 1'b1;
        w(4);
        cmp(slv, c);
        cmp({vld, oe}, 2'h3);
    endtask
    task automatic t_role();
        rst(1'b0);
        cs <= 1'b1;
        w(6);
        cmp(slv, 1'b0);
    endtask
    task automatic t_wait();
        for (int m = 0; m < 3; m++)
        begin
            r.mode <= ihf_pkg::ihf_mode_e'(m);
            r.busy <= 1'b1;
            w(2);
            cmp(pin, 1'b0);
            r.busy <= 1'b0;
            w(2);
            cmp(pin, 1'b1);
        end
    endtask
    task automatic t_wr();
        r.udma_active <= 1'b1;
        r.rx_ready <= 1'b1;
        w(2);
        cmp(pin, 1'b1);
        r.rx_ready <= 1'b0;
        w(2);
        cmp(pin, 1'b0);
    endtask
    task automatic t_rd();
        int e0, k0;
        r.udma_read <= 1'b1;
        w(30);
        e0 = edges;
        k0 = words;
        r.tx_word_valid <= 1'b1;
        w(RD_WORDS * LINK_RATIO);
        r.tx_word_valid <= 1'b0;
        w(60);
        cmp(edges - e0, RD_WORDS);
        cmp(words - k0, RD_WORDS);
        e0 = edges;
        w(80);
        cmp(edges, e0);
        r.tx_word_valid <= 1'b1;
        w(60);
        cmp(edges > e0, 1'b1);
    endtask
    task automatic t_dma();
        ihf_pkg::ihf_core_req_s v;
        v = '0;
        v.mode = ihf_pkg::IHF_MODE_DISK;
        v.dma_want = 1'b1;
        v.irq = 1'b1;
        r <= v;
        w(4);
        cmp({dreq, irq}, 2'h3);
        r.dma_want <= 1'b0;
        w(8);
        cmp(dreq, 1'b0);
        r.dma_want <= 1'b1;
        w(8);
        cmp(dreq, 1'b1);
        r.mode <= ihf_pkg::IHF_MODE_IO;
        w(3);
        cmp({dreq, irq}, 2'h0);
    endtask
    initial
    begin
        t_role();
        t_wait();
        t_wr();
        t_rd();
        t_dma();
        rst(1'b1);
        print_verdict();
    end
    initial
    begin
        #50000;
        fail_count++;
        print_verdict();
    end
endmodule
bind ihf_host_port ihf_host_port_asserts ihf_host_port_asserts_inst (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .dma_ack_n_i(dma_ack_n_i), .req_i(req_i),
    .ready_pin_o(ready_pin_o), .dma_req_o(dma_req_o),
    .host_interrupt_line_o(host_interrupt_line_o), .role_slave_o(role_slave_o),
    .role_valid_o(role_valid_o), .word_taken_o(word_taken_o));
